// File: dv/sfsm_assertions.sv
/* Port checker for sfsm_top, bound into it at the foot of this file.
   Assumes one system clock domain with an async active-high reset. */
`timescale 1ns/1ps
module sfsm_assertions #(
  parameter int SR_WRITE_CYCLES = 200,
  parameter int ERASE_CYCLES    = 3000
) (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ce_n,
  input wire logic       i_data_line3,
  input wire logic       o_data_line0_oe,
  input wire logic       o_data_line1_oe,
  input wire logic       o_data_line2_oe,
  input wire logic       o_data_line3_oe,
  input wire logic [7:0] o_flash_status,
  input wire logic       o_quad_command_mode
);
  logic [15:0] busy_cnt_q;
  logic [2:0]  up_q;
  logic        busy;
  assign busy = o_flash_status[0];
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  // the reload after reset takes one edge, so stability checks wait for up_q
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  AST_RST_VAL: assert property ($fell(i_sys_rst) |-> o_flash_status == 8'h00 ##2
    o_flash_status[1:0] == 2'h0) else $error("status not cleared at reset release");
  AST_OE_CE: assert property (i_ce_n |-> !(o_data_line0_oe | o_data_line1_oe |
    o_data_line2_oe | o_data_line3_oe)) else $error("output driven while deselected");
  AST_QUAD_OE: assert property (!o_quad_command_mode |->
    !(o_data_line0_oe | o_data_line2_oe | o_data_line3_oe)) else $error("quad line driven");
  AST_PAUSE: assert property (!i_ce_n && !i_data_line3 && !o_flash_status[6] &&
    !o_quad_command_mode |-> !o_data_line1_oe) else $error("output not floated in pause");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_q inside
    {[SR_WRITE_CYCLES-2:SR_WRITE_CYCLES+2], [ERASE_CYCLES-2:ERASE_CYCLES+2]})
    else $error("busy time wrong");
  AST_LATCH_CLR: assert property ($fell(busy) |-> !o_flash_status[1])
    else $error("latch not cleared at completion");
  AST_LATCH_BUSY: assert property ($rose(busy) |-> $past(o_flash_status[1]))
    else $error("write started without latch");
  AST_NV_HOLD: assert property (up_q[2] && !$past(busy) && !$past(busy, 2) |->
    $stable(o_flash_status[7:2])) else $error("non-volatile bits changed without write");
  AST_QUAD_QE: assert property ($rose(o_quad_command_mode) |-> o_flash_status[6])
    else $error("quad mode entered with quad enable clear");
  COV_BUSY: cover property ($rose(busy));
  COV_QUAD: cover property ($rose(o_quad_command_mode));
  COV_PAUSE: cover property (!i_ce_n && !i_data_line3 && !o_quad_command_mode);
endmodule : sfsm_assertions
bind sfsm_top sfsm_assertions #(.SR_WRITE_CYCLES(SR_WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
  u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce_n(i_ce_n), .i_data_line3(i_data_line3),
         .o_data_line0_oe(o_data_line0_oe), .o_data_line1_oe(o_data_line1_oe),
         .o_data_line2_oe(o_data_line2_oe), .o_data_line3_oe(o_data_line3_oe),
         .o_flash_status(o_flash_status), .o_quad_command_mode(o_quad_command_mode));

// File: dv/sfsm_spi_master.sv
/* Serial bus master model for the flash front end, mode 0 or mode 3.
   Assumes the bench resolves the shared data lines into i_d. */
`timescale 1ns/1ps
module sfsm_spi_master (
  output logic            o_sck,
  output logic            o_ce_n,
  output logic      [3:0] o_d,
  input  wire logic [3:0] i_d
);
  logic idle = 1'b0;
  logic pause_n = 1'b1;
  logic wp_n = 1'b1;
  initial begin
    o_sck = 1'b0;
    o_ce_n = 1'b1;
    o_d = 4'hc;
  end
  // clock runs only inside a frame; released lines toggle so no stale value reads back
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx, input bit quad,
                      output logic [31:0] rx);
    int w;
    w = quad ? 4 : 1;
    rx = 32'h0000_0000;
    o_sck = idle;
    // the idle level settles before select, so a mode change is no clock edge
    #7.5 o_ce_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i += w) begin
      #7.5 o_sck = 1'b0;
      // lines move just after the falling edge, never in its time step
      #1;
      if (i >= ntx) o_d = quad ? ~o_d : {pause_n, wp_n, ~o_d[1:0]};
      else if (quad) o_d = tx[31 - i -: 4];
      else o_d = {pause_n, wp_n, ~o_d[1], tx[31 - i]};
      #6.5 o_sck = 1'b1;
      if (i >= ntx) rx = quad ? {rx[27:0], i_d} : {rx[30:0], i_d[1]};
    end
    #7.5 o_sck = idle;
    #7.5 o_ce_n = 1'b1;
    #80;
  endtask : xfer
endmodule : sfsm_spi_master

// File: dv/sfsm_top_tb.sv
/* Self-checking bench for sfsm_top with the serial master model.
   Assumes the checker is bound into sfsm_top from its own file. */
`timescale 1ns/1ps
`include "sfsm_defs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR time=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sfsm_top_tb;
  typedef struct packed {
    logic       m3;
    logic       wr_en;
    logic       wp_n;
    logic [7:0] data;
    logic [7:0] exp;
  } sfsm_row_s;
  // rows alternate modes 0 and 3; row 3 must be refused by the pin lock
  sfsm_row_s   rows [5] = '{'{1'b0, 1'b1, 1'b1, 8'h3c, 8'h3c}, '{1'b1, 1'b0, 1'b1, 8'h00, 8'h3c},
                           '{1'b0, 1'b1, 1'b1, 8'h87, 8'h84}, '{1'b1, 1'b1, 1'b0, 8'h00, 8'h84},
                           '{1'b0, 1'b1, 1'b1, 8'h04, 8'h04}};
  logic [24:0] erases [3] = '{25'h080_0000, 25'h07f_f000, 25'h17e_f000};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cold = 1'b1;
  logic        sck;
  logic        ce_n;
  logic        qm;
  logic [3:0]  md;
  logic [3:0]  od;
  logic [3:0]  oe;
  logic [3:0]  line;
  logic [7:0]  st;
  logic [31:0] rx;
  int          miscompares = 0;
  int          checks = 0;
  assign line = (oe & od) | (~oe & md);
  always #5 clk = ~clk;
  sfsm_top #(.SR_WRITE_CYCLES(5), .ERASE_CYCLES(10)) u_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_cold_start(cold), .i_sck(sck), .i_ce_n(ce_n),
    .i_data_line0(line[0]), .i_data_line1(line[1]), .i_data_line2(line[2]),
    .i_data_line3(line[3]), .o_data_line0(od[0]), .o_data_line1(od[1]),
    .o_data_line2(od[2]), .o_data_line3(od[3]), .o_data_line0_oe(oe[0]),
    .o_data_line1_oe(oe[1]), .o_data_line2_oe(oe[2]), .o_data_line3_oe(oe[3]),
    .o_flash_status(st), .o_quad_command_mode(qm));
  sfsm_spi_master u_master (.o_sck(sck), .o_ce_n(ce_n), .o_d(md), .i_d(line));
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic cmd(input logic [31:0] tx, input int n);
    u_master.xfer(tx << (32 - n), n, 0, 1'b0, rx);
  endtask : cmd
  task automatic settle();
    int n;
    n = 0;
    while (st[0] !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(st[0], 1'b0)
  endtask : settle
  task automatic rd_status(input logic [7:0] exp);
    u_master.xfer({`SFSM_STATUS_READ_CMD, 24'h00_0000}, 8, 24, 1'b0, rx);
    `CHK(rx[15:0], {2{exp}})
    `CHK(st, exp)
  endtask : rd_status
  initial begin
    #200_000;
    miscompares++;
    $display("ERROR time=%0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    cold = 1'b0;
    repeat (3) @(posedge clk);
    `CHK(st, `SFSM_STATUS_RST)
    foreach (rows[k]) begin
      u_master.idle = rows[k].m3;
      u_master.wp_n = rows[k].wp_n;
      if (rows[k].wr_en) cmd(`SFSM_WRITE_ENABLE_CMD, 8);
      `CHK(st[1], rows[k].wr_en)
      settle();
      cmd({`SFSM_STATUS_WRITE_CMD, rows[k].data}, 16);
      settle();
      cmd(`SFSM_WRITE_DISABLE_CMD, 8);
      rd_status(rows[k].exp);
      $display("row %0d done", k);
    end
    foreach (erases[k]) begin
      cmd(`SFSM_WRITE_ENABLE_CMD, 8);
      cmd({`SFSM_SECTOR_ERASE_CMD, erases[k][23:0]}, 32);
      `CHK(st[0], erases[k][24])
      settle();
      cmd(`SFSM_WRITE_DISABLE_CMD, 8);
    end
    `CHK(st, 8'h04)
    $display("erase done");
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    `CHK(st, 8'h04)
    fork
      u_master.xfer({`SFSM_STATUS_READ_CMD, 24'h00_0000}, 8, 24, 1'b0, rx);
      begin
        #143;
        `CHK(oe[1], 1'b1)
        u_master.pause_n = 1'b0;
        #30;
        `CHK(oe[1], 1'b0)
        u_master.pause_n = 1'b1;
      end
    join
    $display("reset and pause done");
    u_master.xfer({`SFSM_PARAM_READ_CMD, 24'h00_0000}, 32, 40, 1'b0, rx);
    `CHK(rx, 32'h5346_4450)
    u_master.xfer({`SFSM_PARAM_READ_CMD, 24'h00_000c}, 32, 40, 1'b0, rx);
    `CHK(rx, 32'h3000_00ff)
    cmd(`SFSM_WRITE_ENABLE_CMD, 8);
    cmd({`SFSM_STATUS_WRITE_CMD, 8'h40}, 16);
    settle();
    `CHK(st, 8'h40)
    cmd(`SFSM_QUAD_ENTER_CMD, 8);
    `CHK(qm, 1'b1)
    u_master.xfer({`SFSM_STATUS_READ_CMD, 24'h00_0000}, 8, 16, 1'b1, rx);
    `CHK(rx[15:0], 16'h4040)
    u_master.xfer({`SFSM_QUAD_EXIT_CMD, 24'h00_0000}, 8, 0, 1'b1, rx);
    `CHK(qm, 1'b0)
    $display("quad done");
    end_of_test();
  end
endmodule : sfsm_top_tb

// File: rtl/sfsm_addr_map.sv
/*
  Address map: splits a byte address into sector and block indices and decides
  whether the protect setting covers its 64 Kbyte block (top area).
  Assumes a 24-bit byte address; the top bit lies outside the array.
*/
`timescale 1ns/1ps
`include "sfsm_defs.svh"
module sfsm_addr_map
  import sfsm_pkg::*;
(
  sfsm_map_if.map m
);
  logic [7:0] thresh;

  assign m.sector   = m.addr[22:12];
  assign m.blk32    = m.addr[22:15];
  assign m.blk64    = m.addr[22:16];
  assign m.in_range = ~m.addr[`SFSM_ADDR_TOP_BIT];

  // protected run grows from the top block downward, doubling per step
  assign thresh = `SFSM_BLK64_COUNT - (8'h01 << (m.bp[2:0] - 3'h1));

  always_comb begin
    if (m.bp == 4'h0) begin
      m.protect = 1'b0;
    end else if (m.bp[3]) begin
      m.protect = 1'b1;
    end else begin
      m.protect = ({1'b0, m.blk64} >= thresh);
    end
  end
endmodule : sfsm_addr_map

// File: rtl/sfsm_defs.svh
/*
  Shared constants of the serial flash status and map block: status bit positions,
  reset value, command codes, busy times, address map and discoverable-parameter header.
  Assumes inclusion by bare name from every file that needs a constant.
*/
// What this block does
// - inputs sampled on rising serial clock, outputs launched from falling edge.
// - quad command mode uses all four pins as data lines 0 to 3.
// - array built from 4 Kbyte sectors, 32 and 64 Kbyte blocks.
// - byte addresses 000000h to 7FFFFFh; upper bits give sector and block.
// - discoverable-parameter header with identifier FF00h and basic table provided.
// - a register read repeats the same byte until chip enable rises.
// - status byte: disable 7, quad 6, protect 5..2, latch 1, busy 0; resets zero (here a system reset reloads bits 7..2, only a cold start zeroes them).
// - busy reads one during a status write or sector erase, else zero.
// - latch set by enable command, cleared by disable; status write clears it.
// - four protect bits non-volatile, set by status write, guard blocks.
// - quad enable one allows quad data function, zero disables it.
// - status write disable one marks the status register write-protected.
// - non-volatile bits ship cleared; status read returns the full byte.
// - latch clears when a write completes; each write needs an enable first.
// - disable set with write-protect pin low makes status writes ignored.
// - quad enable one turns pause pin into data line 3.
// - pause low with chip enable low floats output and suspends the transfer.
`ifndef SFSM_DEFS_SVH
`define SFSM_DEFS_SVH

`define SFSM_BIT_BUSY        0
`define SFSM_BIT_LATCH       1
`define SFSM_BIT_QUAD_EN     6
`define SFSM_BIT_WR_DISABLE  7
`define SFSM_STATUS_RST      8'h00
`define SFSM_NV_RST          6'h00

`define SFSM_WRITE_ENABLE_CMD    8'h06
`define SFSM_WRITE_DISABLE_CMD   8'h04
`define SFSM_STATUS_READ_CMD     8'h05
`define SFSM_STATUS_WRITE_CMD    8'h01
`define SFSM_SECTOR_ERASE_CMD    8'h20
`define SFSM_PARAM_READ_CMD      8'h5a
`define SFSM_QUAD_ENTER_CMD      8'h35
`define SFSM_QUAD_EXIT_CMD       8'hf5

`define SFSM_CLK_NS              10
`define SFSM_T_SR_WRITE_NS       2000
`define SFSM_T_SECTOR_ERASE_NS   30000
`define SFSM_PUB_HOLD            4'h8

`define SFSM_ADDR_TOP_BIT        23
`define SFSM_BLK64_COUNT         8'h80

`define SFSM_SFDP_SIG            32'h5044_4653
`define SFSM_SFDP_REV            16'h0106
`define SFSM_SFDP_PARAM_ID       16'hff00
`define SFSM_SFDP_BPT_LEN        8'h02
`define SFSM_SFDP_BPT_PTR        8'h30
`define SFSM_SFDP_BPT_DW1        32'hffff_ffe5
`define SFSM_SFDP_DENSITY        32'h03ff_ffff

`endif

// File: rtl/sfsm_map_if.sv
/*
  Interface between the core and the address map: an address and protect setting in,
  sector and block indices and the protection verdict out.
  Assumes purely combinational use, no clock.
*/
`timescale 1ns/1ps
interface sfsm_map_if;
  import sfsm_pkg::*;
  sfsm_addr_t   addr;
  logic [3:0]   bp;
  logic [10:0]  sector;
  logic [7:0]   blk32;
  logic [6:0]   blk64;
  logic         in_range;
  logic         protect;
  modport req (output addr, output bp, input sector, input blk32, input blk64,
               input in_range, input protect);
  modport map (input addr, input bp, output sector, output blk32, output blk64,
               output in_range, output protect);
endinterface : sfsm_map_if

// File: rtl/sfsm_pkg.sv
/*
  Types of the serial flash status and map block: link and core states, address type.
  Assumes nothing of its surroundings.
*/
package sfsm_pkg;
  typedef enum logic [2:0] {LK_CMD, LK_ADDR, LK_DUMMY, LK_WDATA, LK_RDATA, LK_DROP} sfsm_link_e;
  typedef enum logic [1:0] {CS_LOAD, CS_IDLE, CS_SR_WRITE, CS_ERASE} sfsm_core_e;
  typedef logic [23:0] sfsm_addr_t;
endpackage : sfsm_pkg

// File: rtl/sfsm_sync.sv
/*
  Two flip-flop synchroniser, W bits wide.
  Assumes each bit is an independent level or a toggle, or the word is a gray count.
*/
`timescale 1ns/1ps
module sfsm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule : sfsm_sync

// File: rtl/sfsm_top.sv
/*
  Serial flash front end and status register: serial link on the master's clock,
  status, protection and busy timing on the system clock.
  Assumes the master keeps one command per chip-enable frame and that the serial
  clock may stop between frames.
*/
`timescale 1ns/1ps
`include "sfsm_defs.svh"
module sfsm_top
  import sfsm_pkg::*;
#(
  parameter int SR_WRITE_CYCLES =
    (`SFSM_T_SR_WRITE_NS + `SFSM_CLK_NS - 1) / `SFSM_CLK_NS,
  parameter int ERASE_CYCLES    =
    (`SFSM_T_SECTOR_ERASE_NS + `SFSM_CLK_NS - 1) / `SFSM_CLK_NS
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_cold_start,
  input  wire logic       i_sck,
  input  wire logic       i_ce_n,
  input  wire logic       i_data_line0,
  input  wire logic       i_data_line1,
  input  wire logic       i_data_line2,
  input  wire logic       i_data_line3,
  output logic            o_data_line0,
  output logic            o_data_line1,
  output logic            o_data_line2,
  output logic            o_data_line3,
  output logic            o_data_line0_oe,
  output logic            o_data_line1_oe,
  output logic            o_data_line2_oe,
  output logic            o_data_line3_oe,
  output logic [7:0]      o_flash_status,
  output logic            o_quad_command_mode
);

  // link-side state
  sfsm_link_e   ls_q;
  logic [4:0]   cnt_q;
  logic [23:0]  sh_q;
  logic [7:0]   op_q;
  logic [7:0]   rd_byte_q;
  logic [7:0]   rd_ptr_q;
  logic [3:0]   out_q;
  logic         oe_q;
  logic         quad_q;
  logic [7:0]   status_lk_q;
  logic [1:0]   lk_gray_seen_q;
  logic [1:0]   lk_gray_s;
  logic [7:0]   ev_op_q;
  logic [7:0]   ev_data_q;
  sfsm_addr_t   ev_addr_q;
  logic         ev_tgl_q;

  // core-side state
  sfsm_core_e   cs_q;
  logic [15:0]  busy_cnt_q;
  logic [5:0]   nv_q;
  logic [5:0]   nvw_q;
  logic [7:0]   pend_q;
  logic         latch_q;
  logic         busy_q;
  logic         ev_seen_q;
  logic [7:0]   pub_q;
  logic [1:0]   pub_gray_q;
  logic [3:0]   pub_hold_q;

  // link-side combinational
  logic         lk_rst;
  logic         hold_ok;
  logic         quad_en_lk;
  logic [4:0]   step;
  logic [3:0]   nib;
  logic [23:0]  sh_nx;
  logic [4:0]   cnt_nx;
  logic         fdone;
  logic [7:0]   cmd_nx;
  logic         post;

  // core-side combinational
  logic [1:0]   core_s;
  logic         ev_fire;
  logic         wp_low;
  logic         sr_write_ok;
  logic         erase_ok;
  logic         done;
  logic [7:0]   status;

  sfsm_map_if map_if ();

  function automatic logic [4:0] field_len(input sfsm_link_e s);
    field_len = (s == LK_ADDR) ? 5'h18 : 5'h08;
  endfunction : field_len

  // little-endian header and basic table; unmapped bytes read as erased
  function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
    case (a)
      8'h00:   sfdp_byte = 8'(`SFSM_SFDP_SIG);
      8'h01:   sfdp_byte = 8'(`SFSM_SFDP_SIG >> 8);
      8'h02:   sfdp_byte = 8'(`SFSM_SFDP_SIG >> 16);
      8'h03:   sfdp_byte = 8'(`SFSM_SFDP_SIG >> 24);
      8'h04:   sfdp_byte = 8'(`SFSM_SFDP_REV);
      8'h05:   sfdp_byte = 8'(`SFSM_SFDP_REV >> 8);
      8'h06:   sfdp_byte = 8'h00;
      8'h07:   sfdp_byte = 8'hff;
      8'h08:   sfdp_byte = 8'(`SFSM_SFDP_PARAM_ID);
      8'h09:   sfdp_byte = 8'(`SFSM_SFDP_REV);
      8'h0a:   sfdp_byte = 8'(`SFSM_SFDP_REV >> 8);
      8'h0b:   sfdp_byte = `SFSM_SFDP_BPT_LEN;
      8'h0c:   sfdp_byte = `SFSM_SFDP_BPT_PTR;
      8'h0d:   sfdp_byte = 8'h00;
      8'h0e:   sfdp_byte = 8'h00;
      8'h0f:   sfdp_byte = 8'(`SFSM_SFDP_PARAM_ID >> 8);
      8'h30:   sfdp_byte = 8'(`SFSM_SFDP_BPT_DW1);
      8'h31:   sfdp_byte = 8'(`SFSM_SFDP_BPT_DW1 >> 8);
      8'h32:   sfdp_byte = 8'(`SFSM_SFDP_BPT_DW1 >> 16);
      8'h33:   sfdp_byte = 8'(`SFSM_SFDP_BPT_DW1 >> 24);
      8'h34:   sfdp_byte = 8'(`SFSM_SFDP_DENSITY);
      8'h35:   sfdp_byte = 8'(`SFSM_SFDP_DENSITY >> 8);
      8'h36:   sfdp_byte = 8'(`SFSM_SFDP_DENSITY >> 16);
      8'h37:   sfdp_byte = 8'(`SFSM_SFDP_DENSITY >> 24);
      default: sfdp_byte = 8'hff;
    endcase
  endfunction : sfdp_byte

  function automatic sfsm_link_e after_cmd(input logic [7:0] c);
    case (c)
      `SFSM_STATUS_WRITE_CMD: after_cmd = LK_WDATA;
      `SFSM_STATUS_READ_CMD:  after_cmd = LK_RDATA;
      `SFSM_SECTOR_ERASE_CMD: after_cmd = LK_ADDR;
      `SFSM_PARAM_READ_CMD:   after_cmd = LK_ADDR;
      default:                after_cmd = LK_DROP;
    endcase
  endfunction : after_cmd

  // serial link, clocked by the master's serial clock

  assign lk_rst  = i_ce_n | i_sys_rst;
  assign quad_en_lk = status_lk_q[`SFSM_BIT_QUAD_EN];
  assign hold_ok = quad_en_lk | i_data_line3;
  assign step    = quad_q ? 5'h04 : 5'h01;
  assign nib     = {i_data_line3, i_data_line2, i_data_line1, i_data_line0};
  assign sh_nx   = quad_q ? {sh_q[19:0], nib} : {sh_q[22:0], i_data_line0};
  assign cnt_nx  = cnt_q + step;
  assign fdone   = (cnt_nx == field_len(ls_q));
  assign cmd_nx  = sh_nx[7:0];

  always_comb begin
    post = 1'b0;
    if (fdone) begin
      unique case (ls_q)
        LK_CMD:   post = (cmd_nx == `SFSM_WRITE_ENABLE_CMD) |
                         (cmd_nx == `SFSM_WRITE_DISABLE_CMD);
        LK_ADDR:  post = (op_q == `SFSM_SECTOR_ERASE_CMD);
        LK_WDATA: post = 1'b1;
        LK_DUMMY: post = 1'b0;
        LK_RDATA: post = 1'b0;
        LK_DROP:  post = 1'b0;
      endcase
    end
  end

  // input bits taken on the rising edge; pause freezes the sequence in place
  always_ff @(posedge i_sck or posedge lk_rst) begin
    if (lk_rst) begin
      ls_q      <= LK_CMD;
      cnt_q     <= 5'h00;
      sh_q      <= 24'h00_0000;
      op_q      <= 8'h00;
      rd_byte_q <= 8'h00;
      rd_ptr_q  <= 8'h00;
    end else if (hold_ok) begin
      cnt_q <= fdone ? 5'h00 : cnt_nx;
      sh_q  <= sh_nx;
      if (fdone) begin
        unique case (ls_q)
          LK_CMD: begin
            op_q <= cmd_nx;
            ls_q <= after_cmd(cmd_nx);
            rd_byte_q <= status_lk_q;
          end
          LK_ADDR: begin
            rd_ptr_q <= sh_nx[7:0];
            ls_q     <= (op_q == `SFSM_PARAM_READ_CMD) ? LK_DUMMY : LK_DROP;
          end
          LK_DUMMY: begin
            ls_q      <= LK_RDATA;
            rd_byte_q <= sfdp_byte(rd_ptr_q);
            rd_ptr_q  <= rd_ptr_q + 8'h01;
          end
          LK_RDATA: begin
            // a status read keeps the byte it started with
            if (op_q == `SFSM_PARAM_READ_CMD) begin
              rd_byte_q <= sfdp_byte(rd_ptr_q);
              rd_ptr_q  <= rd_ptr_q + 8'h01;
            end
          end
          LK_WDATA: ls_q <= LK_DROP;
          LK_DROP:  ls_q <= LK_DROP;
        endcase
      end
    end
  end

  // output bits launched on the falling edge; a mode 3 frame opens with one
  // falling edge that only loads an idle output
  always_ff @(negedge i_sck or posedge lk_rst) begin
    if (lk_rst) begin
      out_q <= 4'h0;
      oe_q  <= 1'b0;
    end else if (hold_ok) begin
      oe_q <= (ls_q == LK_RDATA);
      if (quad_q) begin
        out_q <= cnt_q[2] ? rd_byte_q[3:0] : rd_byte_q[7:4];
      end else begin
        out_q <= {2'b00, rd_byte_q[3'h7 - cnt_q[2:0]], 1'b0};
      end
    end
  end

  // posted command: word held until the next command, flagged by a toggle
  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_op_q   <= 8'h00;
      ev_data_q <= 8'h00;
      ev_addr_q <= 24'h00_0000;
      ev_tgl_q  <= 1'b0;
    end else if (post && hold_ok && !i_ce_n) begin
      ev_op_q   <= (ls_q == LK_CMD) ? cmd_nx : op_q;
      ev_data_q <= sh_nx[7:0];
      ev_addr_q <= sh_nx;
      ev_tgl_q  <= ~ev_tgl_q;
    end
  end

  // quad mode outlives the frame; it falls away when quad enable is cleared
  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quad_q <= 1'b0;
    end else if (!quad_en_lk) begin
      quad_q <= 1'b0;
    end else if (!i_ce_n && hold_ok && fdone && ls_q == LK_CMD) begin
      if (cmd_nx == `SFSM_QUAD_ENTER_CMD) begin
        quad_q <= 1'b1;
      end else if (cmd_nx == `SFSM_QUAD_EXIT_CMD) begin
        quad_q <= 1'b0;
      end
    end
  end

  // a gray count, not a toggle: two updates while the clock stops still differ
  sfsm_sync #(.W(2)) u_lk_sync (
    .i_clk (i_sck),
    .i_rst (i_sys_rst),
    .i_d   (pub_gray_q),
    .o_q   (lk_gray_s)
  );

  // the copy only refreshes while the clock runs, so the first edges of a
  // frame may still show the previous status
  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_lk_q    <= `SFSM_STATUS_RST;
      lk_gray_seen_q <= 2'h0;
    end else if (lk_gray_s != lk_gray_seen_q) begin
      // a word caught mid-update is replaced once its own count arrives
      status_lk_q    <= pub_q;
      lk_gray_seen_q <= lk_gray_s;
    end
  end

  assign o_data_line0        = out_q[0];
  assign o_data_line1        = out_q[1];
  assign o_data_line2        = out_q[2];
  assign o_data_line3        = out_q[3];
  assign o_data_line1_oe     = oe_q & ~i_ce_n & hold_ok;
  assign o_data_line0_oe     = oe_q & ~i_ce_n & quad_q;
  assign o_data_line2_oe     = oe_q & ~i_ce_n & quad_q;
  assign o_data_line3_oe     = oe_q & ~i_ce_n & quad_q;
  assign o_quad_command_mode = quad_q;

  // core, clocked by the system clock

  sfsm_sync #(.W(2)) u_core_sync (
    .i_clk (i_clk),
    .i_rst (i_sys_rst),
    .i_d   ({i_data_line2, ev_tgl_q}),
    .o_q   (core_s)
  );

  assign ev_fire = core_s[0] ^ ev_seen_q;
  // with quad enable set the protect pin carries data and cannot lock
  assign wp_low  = ~nvw_q[`SFSM_BIT_QUAD_EN - 2] & ~core_s[1];

  assign map_if.addr = ev_addr_q;
  assign map_if.bp   = nvw_q[3:0];

  sfsm_addr_map u_map (
    .m (map_if.map)
  );

  // every write must find the latch set and the device idle
  assign sr_write_ok = latch_q & (cs_q == CS_IDLE) &
                       ~(nvw_q[`SFSM_BIT_WR_DISABLE - 2] & wp_low);
  assign erase_ok    = latch_q & (cs_q == CS_IDLE) & map_if.in_range &
                       ~map_if.protect;
  assign done        = busy_q & (busy_cnt_q == 16'h0000);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_seen_q <= 1'b0;
    end else begin
      ev_seen_q <= core_s[0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_q       <= CS_LOAD;
      busy_q     <= 1'b0;
      busy_cnt_q <= 16'h0000;
      pend_q     <= 8'h00;
    end else begin
      unique case (cs_q)
        CS_LOAD: cs_q <= CS_IDLE;
        CS_IDLE: begin
          if (ev_fire && ev_op_q == `SFSM_STATUS_WRITE_CMD && sr_write_ok) begin
            cs_q       <= CS_SR_WRITE;
            busy_q     <= 1'b1;
            busy_cnt_q <= 16'(SR_WRITE_CYCLES - 1);
            pend_q     <= ev_data_q;
          end else if (ev_fire && ev_op_q == `SFSM_SECTOR_ERASE_CMD && erase_ok) begin
            cs_q       <= CS_ERASE;
            busy_q     <= 1'b1;
            busy_cnt_q <= 16'(ERASE_CYCLES - 1);
          end
        end
        CS_SR_WRITE, CS_ERASE: begin
          if (done) begin
            cs_q   <= CS_IDLE;
            busy_q <= 1'b0;
          end else begin
            busy_cnt_q <= busy_cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // non-volatile cells survive the system reset; only a cold start clears them
  always_ff @(posedge i_clk or posedge i_cold_start) begin
    if (i_cold_start) begin
      nv_q <= `SFSM_NV_RST;
    end else if (done && cs_q == CS_SR_WRITE) begin
      nv_q <= pend_q[7:2];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nvw_q <= `SFSM_NV_RST;
    end else if (cs_q == CS_LOAD) begin
      nvw_q <= nv_q;
    end else if (done && cs_q == CS_SR_WRITE) begin
      nvw_q <= pend_q[7:2];
    end
  end

  // an enable arriving as a write completes wins over the automatic clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      latch_q <= 1'b0;
    end else if (ev_fire && ev_op_q == `SFSM_WRITE_ENABLE_CMD) begin
      latch_q <= 1'b1;
    end else if ((ev_fire && ev_op_q == `SFSM_WRITE_DISABLE_CMD) || done) begin
      latch_q <= 1'b0;
    end
  end

  assign status = {nvw_q, latch_q, busy_q};

  // publish to the link side, holding each word long enough to be caught
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pub_q      <= `SFSM_STATUS_RST;
      pub_gray_q <= 2'h0;
      pub_hold_q <= 4'h0;
    end else if (pub_hold_q != 4'h0) begin
      pub_hold_q <= pub_hold_q - 4'h1;
    end else if (pub_q != status) begin
      pub_q      <= status;
      pub_gray_q <= {pub_gray_q[0], ~pub_gray_q[1]};
      pub_hold_q <= `SFSM_PUB_HOLD;
    end
  end

  assign o_flash_status = status;

endmodule : sfsm_top
